// ===== rtl/pldrm_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "pldrm_defs.svh"

module pldrm_top (
	input  wire logic        core_clk,
	input  wire logic        rst,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Terms from the logic array
	input  wire logic [19:0] sum_term,
	input  wire logic [19:0] areset_term,
	input  wire logic [19:0] clk_term,
	input  wire logic [9:0]  oe_term,
	input  wire logic        sync_preset,
	// Device pins
	input  wire logic        clk_pin,
	input  wire logic        preload_mode,
	input  wire logic        preload_sel,
	input  wire logic [9:0]  io_in,
	output logic      [9:0]  io_out,
	output logic      [9:0]  io_oe,
	// Feedback into the array
	output logic      [19:0] ff_feedback,
	output logic      [9:0]  io_feedback
);

	// Configuration and readback masking
	function automatic logic [31:0] cfg_read(
		input logic [31:0] value,
		input logic        secure
	);
		cfg_read = secure ? 32'hFFFFFFFF : value;
	endfunction : cfg_read

	function automatic logic mapped(input logic [7:0] addr);
		mapped = (addr == `PLDRM_OFS_CTRL) || (addr == `PLDRM_OFS_TTYPE) ||
			(addr == `PLDRM_OFS_PINCLK) || (addr == `PLDRM_OFS_POL) ||
			(addr == `PLDRM_OFS_STATE) || (addr == `PLDRM_OFS_PINS);
	endfunction : mapped

	logic [1:0]  ctrl_q;
	logic [19:0] ttype_q;
	logic [19:0] pinclk_q;
	logic [9:0]  pol_q;

	logic        compat;
	logic        secure;

	assign compat = ctrl_q[`PLDRM_CTRL_COMPAT];
	assign secure = ctrl_q[`PLDRM_CTRL_SECURE];

	// Pin synchronisers
	logic [12:0] pins_raw;
	logic [12:0] pins_s;
	logic        clk_pin_s;
	logic        preload_s;
	logic        sel_s;
	logic [9:0]  io_s;

	assign pins_raw = {clk_pin, preload_mode, preload_sel, io_in};

	pldrm_sync #(
		.WIDTH(13)
	) u_pin_sync (
		.core_clk(core_clk),
		.rst     (rst),
		.d       (pins_raw),
		.q       (pins_s)
	);

	assign clk_pin_s = pins_s[12];
	assign preload_s = pins_s[11];
	assign sel_s     = pins_s[10];
	assign io_s      = pins_s[9:0];

	// Clock edge detection
	logic        clk_pin_prev_q;
	logic [19:0] term_prev_q;
	logic        pin_rise;
	logic [19:0] term_rise;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			clk_pin_prev_q <= 1'b0;
			term_prev_q    <= 20'h00000;
		end else begin
			clk_pin_prev_q <= clk_pin_s;
			term_prev_q    <= clk_term;
		end
	end

	assign pin_rise  = clk_pin_s & ~clk_pin_prev_q;
	assign term_rise = clk_term & ~term_prev_q;

	// Twenty register flip-flops, two per output cell
	pldrm_pkg::pldrm_ff_vec_type ff_q;
	logic [19:0]                 ff_clk_en;
	logic [19:0]                 ff_load_en;
	logic [19:0]                 ff_load_val;

	pldrm_pkg::pldrm_kind_type   ff_kind [20];
	pldrm_pkg::pldrm_src_type    ff_src  [20];

	genvar gi;
	generate
		for (gi = 0; gi < `PLDRM_NUM_FF; gi++) begin : g_ff
			always_comb begin
				if (compat || !ttype_q[gi]) begin
					ff_kind[gi] = pldrm_pkg::PLDRM_D_TYPE;
				end else begin
					ff_kind[gi] = pldrm_pkg::PLDRM_T_TYPE;
				end
			end

			always_comb begin
				if (compat || !pinclk_q[gi]) begin
					ff_src[gi] = pldrm_pkg::PLDRM_SRC_TERM;
				end else begin
					ff_src[gi] = pldrm_pkg::PLDRM_SRC_PIN;
				end
			end

			// Each flop advances on its own selected edge
			assign ff_clk_en[gi] = (ff_src[gi] == pldrm_pkg::PLDRM_SRC_PIN) ?
				pin_rise : term_rise[gi];

			// Even register is #0 of its cell, odd register is #1
			assign ff_load_en[gi]  = preload_s &
				(sel_s == ((gi % 2) == 1));
			assign ff_load_val[gi] = io_s[gi / 2];

			pldrm_flop u_flop (
				.core_clk   (core_clk),
				.rst        (rst),
				.clk_en     (ff_clk_en[gi]),
				.sum_term   (sum_term[gi]),
				.areset_term(areset_term[gi]),
				.kind       (ff_kind[gi]),
				.preset     (sync_preset),
				.load_en    (ff_load_en[gi]),
				.load_val   (ff_load_val[gi]),
				.q          (ff_q[gi])
			);
		end
	endgenerate

	// Pin and feedback drivers
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			io_out <= 10'h000;
		end else begin
			for (int c = 0; c < `PLDRM_NUM_CELL; c++) begin
				io_out[c] <= ff_q[2 * c] ^ pol_q[c];
			end
		end
	end

	// Pins released during preload so they can be forced
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			io_oe <= 10'h000;
		end else if (preload_s) begin
			io_oe <= 10'h000;
		end else begin
			io_oe <= oe_term;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ff_feedback <= 20'h00000;
			io_feedback <= 10'h000;
		end else begin
			ff_feedback <= ff_q;
			io_feedback <= io_s;
		end
	end

	// APB slave: answer in the access cycle, no wait states
	logic setup_phase;
	logic access_done;
	logic wr_en;

	assign setup_phase = psel & ~penable;
	assign access_done = psel & penable & pready;
	assign wr_en       = access_done & pwrite & ~pslverr;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else if (setup_phase) begin
			pready  <= 1'b1;
			pslverr <= ~mapped(paddr);
		end else if (access_done) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			prdata <= 32'h00000000;
		end else if (setup_phase && !pwrite) begin
			unique case (paddr)
				`PLDRM_OFS_CTRL: begin
					prdata <= cfg_read({30'h00000000, ctrl_q}, secure);
				end
				`PLDRM_OFS_TTYPE: begin
					prdata <= cfg_read({12'h000, ttype_q}, secure);
				end
				`PLDRM_OFS_PINCLK: begin
					prdata <= cfg_read({12'h000, pinclk_q}, secure);
				end
				`PLDRM_OFS_POL: begin
					prdata <= cfg_read({22'h000000, pol_q}, secure);
				end
				`PLDRM_OFS_STATE: begin
					prdata <= {12'h000, ff_q};
				end
				`PLDRM_OFS_PINS: begin
					prdata <= {12'h000, io_oe, io_s};
				end
				default: begin
					prdata <= 32'h00000000;
				end
			endcase
		end else if (access_done) begin
			prdata <= 32'h00000000;
		end
	end

	// Security fuse sets once and locks configuration writes
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ctrl_q <= `PLDRM_RST_CTRL;
		end else if (wr_en && paddr == `PLDRM_OFS_CTRL) begin
			if (!secure) begin
				ctrl_q[`PLDRM_CTRL_COMPAT] <= pwdata[`PLDRM_CTRL_COMPAT];
			end
			if (pwdata[`PLDRM_CTRL_SECURE]) begin
				ctrl_q[`PLDRM_CTRL_SECURE] <= 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ttype_q <= `PLDRM_RST_TTYPE;
		end else if (wr_en && !secure && paddr == `PLDRM_OFS_TTYPE) begin
			ttype_q <= pwdata[19:0];
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pinclk_q <= `PLDRM_RST_PINCLK;
		end else if (wr_en && !secure && paddr == `PLDRM_OFS_PINCLK) begin
			pinclk_q <= pwdata[19:0];
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pol_q <= `PLDRM_RST_POL;
		end else if (wr_en && !secure && paddr == `PLDRM_OFS_POL) begin
			pol_q <= pwdata[9:0];
		end
	end

endmodule : pldrm_top

`default_nettype wire

// ===== rtl/pldrm_defs.svh
// Operation
// - Each flip-flop is set separately as D-type or T-type.
// - T-type mode plus array logic builds JK and SR behaviour.
// - Each flip-flop clocks from its own term or the clock pin.
// - Two flip-flops per output cell, twenty registers in all.
// - Each register has its own sum, reset and clock term.
// - Every register feeds back; every I/O pin keeps its input path.
// - Each I/O pin output enable comes from its own term.
// - Compatibility mode: all D-type, all clocked by product term.
// - One synchronous preset acts on all twenty registers.
// - Each flip-flop's reset term clears it at once.
// - With security fuse set, configuration reads back all ones.
// - Power-up clears every register low; pins follow polarity.
// - Preload: clock pulse loads pin level into the selected register.
`ifndef PLDRM_DEFS_SVH
`define PLDRM_DEFS_SVH

`define PLDRM_NUM_FF       20
`define PLDRM_NUM_CELL     10
`define PLDRM_ADDR_W       8

`define PLDRM_OFS_CTRL     8'h00
`define PLDRM_OFS_TTYPE    8'h04
`define PLDRM_OFS_PINCLK   8'h08
`define PLDRM_OFS_POL      8'h0C
`define PLDRM_OFS_STATE    8'h10
`define PLDRM_OFS_PINS     8'h14

`define PLDRM_CTRL_COMPAT  0
`define PLDRM_CTRL_SECURE  1

`define PLDRM_RST_CTRL     2'h0
`define PLDRM_RST_TTYPE    20'h00000
`define PLDRM_RST_PINCLK   20'h00000
`define PLDRM_RST_POL      10'h000

`endif

// ===== rtl/pldrm_pkg.sv
package pldrm_pkg;

	typedef enum logic {
		PLDRM_D_TYPE,
		PLDRM_T_TYPE
	} pldrm_kind_type;

	typedef enum logic {
		PLDRM_SRC_TERM,
		PLDRM_SRC_PIN
	} pldrm_src_type;

	typedef logic [19:0] pldrm_ff_vec_type;

endpackage : pldrm_pkg

// ===== rtl/pldrm_sync.sv
`timescale 1ns/1ns
`default_nettype none

module pldrm_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             core_clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			meta_q <= '0;
			q      <= '0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end

endmodule : pldrm_sync

`default_nettype wire

// ===== rtl/pldrm_flop.sv
`timescale 1ns/1ns
`default_nettype none

module pldrm_flop (
	input  wire logic                    core_clk,
	input  wire logic                    rst,
	input  wire logic                    clk_en,
	input  wire logic                    sum_term,
	input  wire logic                    areset_term,
	input  wire pldrm_pkg::pldrm_kind_type kind,
	input  wire logic                    preset,
	input  wire logic                    load_en,
	input  wire logic                    load_val,
	output logic                         q
);

	logic state_q;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_q <= 1'b0;
		end else if (areset_term) begin
			state_q <= 1'b0;
		end else if (clk_en) begin
			if (load_en) begin
				state_q <= load_val;
			end else if (preset) begin
				state_q <= 1'b1;
			end else if (kind == pldrm_pkg::PLDRM_T_TYPE) begin
				state_q <= state_q ^ sum_term;
			end else begin
				state_q <= sum_term;
			end
		end
	end

	// Reset term clears the visible value in the same cycle
	assign q = areset_term ? 1'b0 : state_q;

endmodule : pldrm_flop

`default_nettype wire

// ===== tb/pldrm_properties.sv
`timescale 1ns/1ns
`default_nettype none
module pldrm_properties (
	input wire logic        core_clk,
	input wire logic        rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        clk_pin,
	input wire logic        preload_mode,
	input wire logic [19:0] areset_term,
	input wire logic [19:0] clk_term,
	input wire logic [19:0] ff_feedback,
	input wire logic [9:0]  oe_term,
	input wire logic [9:0]  io_in,
	input wire logic [9:0]  io_oe,
	input wire logic [9:0]  io_out,
	input wire logic [9:0]  io_feedback
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	logic [2:0] quiet_q;
	// Cycles with no clock source and no reset term
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			quiet_q <= 3'h0;
		else if (clk_pin || clk_term != 20'h0 || areset_term != 20'h0)
			quiet_q <= 3'h0;
		else if (quiet_q != 3'h7)
			quiet_q <= quiet_q + 3'h1;
	end
	AST_RDY: assert property (psel && !penable |=> pready)
		else $error("pready missing in access cycle");
	AST_RDY_ONE: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	AST_IDLE: assert property (!psel |=> !pready)
		else $error("pready without select");
	AST_ERR: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	AST_OE: assert property (
		!preload_mode [*4] |=> io_oe == $past(oe_term))
		else $error("io_oe does not follow its term");
	AST_OE_PRE: assert property (
		preload_mode [*4] |=> io_oe == 10'h000)
		else $error("io_oe active in preload");
	AST_IOFB: assert property (
		$stable(io_in) [*4] |=> io_feedback == $past(io_in))
		else $error("io_feedback lost pin level");
	AST_FFRST: assert property (
		(ff_feedback & $past(areset_term, 2)) == 20'h0)
		else $error("reset term did not clear flop");
	AST_HOLD: assert property (
		quiet_q == 3'h7 |-> $stable(ff_feedback))
		else $error("flop changed without clock");
	AST_PWRUP: assert property (
		$past(rst) |-> ff_feedback == 20'h0 && io_out == 10'h0)
		else $error("flops not low after reset");
	cover property (pready && pslverr);
	cover property (areset_term != 20'h0);
	cover property (preload_mode [*4]);
endmodule : pldrm_properties
`default_nettype wire

// ===== tb/pldrm_ext.sv
`timescale 1ns/1ns
`default_nettype none
module pldrm_ext (
	input  wire logic       core_clk,
	input  wire logic       fire,
	input  wire logic [9:0] drive_val,
	output logic            clk_pin,
	output logic [9:0]      io_in
);
	logic [1:0] cnt_q = 2'h0;
	initial clk_pin = 1'b0;
	initial io_in = 10'h000;
	always @(posedge core_clk) begin
		io_in <= drive_val;
		cnt_q <= fire ? 2'h3 : cnt_q - 2'(cnt_q != 2'h0);
		// Pin edge falls inside the preset window of the bench
		clk_pin <= fire || cnt_q != 2'h0;
	end
endmodule : pldrm_ext
`default_nettype wire

// ===== tb/pldrm_register_macrocell_test.sv
`timescale 1ns/1ns
`default_nettype none
module pld_register_macrocell_test;
	logic        core_clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel, penable, pwrite, sync_preset, preload_sel, fire;
	logic        pready, pslverr, clk_pin, preload_mode;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, seed = 32'h2733;
	logic [19:0] sum_term, areset_term, clk_term, ff_feedback, st, e, sm, pc;
	logic [9:0]  oe_term, io_in, io_out, io_oe, io_feedback, drive_val, v, pl;
	int          err_total = 0;
	int          tests_run = 0;
	always #2 core_clk = ~core_clk;
	pldrm_top i_pldrm_top (.core_clk, .rst, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .sum_term,
		.areset_term, .clk_term, .oe_term, .sync_preset, .clk_pin,
		.preload_mode, .preload_sel, .io_in, .io_out, .io_oe,
		.ff_feedback, .io_feedback);
	pldrm_ext i_pldrm_ext (.core_clk, .fire, .drive_val, .clk_pin, .io_in);
	function automatic logic [31:0] nx();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : nx
	function automatic logic [19:0] f_exp(input logic [19:0] s, d, k,
		input logic t);
		return t ? s ^ (d & k) : (s & ~k) | (d & k);
	endfunction : f_exp
	task automatic wrap_up();
		$display("Checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [31:0] x, input logic [31:0] g);
		tests_run++;
		if (g !== x) begin
			err_total++;
			$display("Error t=%0t exp %h got %h", $time, x, g);
		end
	endtask : chk
	task automatic acc(input logic w, input logic [7:0] a,
		input logic [31:0] d, x, input logic xe);
		int n;
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 9);
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			err_total++;
			wrap_up();
		end else begin
			if (!w)
				chk(x, prdata);
			chk({31'h0, xe}, {31'h0, pslverr});
		end
	endtask : acc
	task automatic step(input logic t, input logic [19:0] pc);
		logic [19:0] d, m, r;
		logic        p;
		d = 20'(nx());
		m = 20'(nx());
		r = 20'(nx() & nx() & nx());
		p = d[0] ^ m[1];
		sum_term <= d;
		areset_term <= r;
		sync_preset <= p;
		oe_term <= d[9:0] ^ m[9:0];
		@(posedge core_clk);
		clk_term <= m;
		fire <= 1'b1;
		@(posedge core_clk);
		clk_term <= 20'h0;
		fire <= 1'b0;
		repeat (6) @(posedge core_clk);
		areset_term <= 20'h0;
		sync_preset <= 1'b0;
		st = (p ? st | m | pc : f_exp(st, d, m | pc, t)) & ~r;
		acc(1'b0, 8'h10, 32'h0, {12'h0, st}, 1'b0);
		chk({12'h0, st}, {12'h0, ff_feedback});
	endtask : step
	initial begin
		{psel, penable, pwrite, sync_preset, preload_mode} = 5'h00;
		{preload_sel, fire, paddr, pwdata, sum_term} = 62'h0;
		{areset_term, clk_term, oe_term, drive_val, st} = 80'h0;
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		for (int i = 0; i < 6; i++)
			acc(1'b0, 8'(4 * i), 32'h0, 32'h0, 1'b0);
		acc(1'b1, 8'h18, 32'h5, 32'h0, 1'b1);
		acc(1'b0, 8'h18, 32'h0, 32'h0, 1'b1);
		$display("reset test done");
		for (int t = 0; t < 2; t++) begin
			acc(1'b1, 8'h04, {12'h0, {20{t[0]}}}, 32'h0, 1'b0);
			repeat (8) step(t[0], 20'h0);
		end
		acc(1'b1, 8'h00, 32'h1, 32'h0, 1'b0);
		acc(1'b1, 8'h08, 32'hFFFFF, 32'h0, 1'b0);
		repeat (4) step(1'b0, 20'h0);
		acc(1'b1, 8'h00, 32'h0, 32'h0, 1'b0);
		pc = 20'(nx());
		acc(1'b1, 8'h08, {12'h0, pc}, 32'h0, 1'b0);
		repeat (6) step(1'b1, pc);
		$display("flop test done");
		acc(1'b1, 8'h08, 32'h0, 32'h0, 1'b0);
		for (int s = 1; s >= 0; s--) begin
			v = 10'(nx());
			drive_val <= v;
			preload_mode <= 1'b1;
			preload_sel <= s[0];
			repeat (5) @(posedge core_clk);
			chk(32'h0, {22'h0, io_oe});
			acc(1'b0, 8'h14, 32'h0, {22'h0, v}, 1'b0);
			clk_term <= 20'hFFFFF;
			@(posedge core_clk);
			clk_term <= 20'h0;
			repeat (3) @(posedge core_clk);
			sm = s ? 20'hAAAAA : 20'h55555;
			for (int c = 0; c < 10; c++)
				e[2 * c +: 2] = {2{v[c]}};
			chk({12'h0, e & sm}, {12'h0, ff_feedback & sm});
		end
		preload_mode <= 1'b0;
		pl = 10'(nx());
		acc(1'b1, 8'h0C, {22'h0, pl}, 32'h0, 1'b0);
		repeat (3) @(posedge core_clk);
		chk({22'h0, v ^ pl}, {22'h0, io_out});
		$display("preload test done");
		acc(1'b1, 8'h04, 32'h0, 32'h0, 1'b0);
		acc(1'b1, 8'h00, 32'h2, 32'h0, 1'b0);
		for (int i = 0; i < 4; i++)
			acc(1'b0, 8'(4 * i), 32'h0, 32'hFFFFFFFF, 1'b0);
		$display("security test done");
		wrap_up();
	end
endmodule : pld_register_macrocell_test
bind pldrm_top pldrm_properties i_pldrm_properties (.core_clk, .rst,
	.psel, .penable, .pready, .pslverr, .clk_pin, .preload_mode,
	.areset_term, .clk_term, .ff_feedback, .oe_term, .io_in, .io_oe,
	.io_out, .io_feedback);
`default_nettype wire
